// ---- fp_mul_cmp_pkg.sv ----
package fp_mul_cmp_pkg;

  // ----------------------------------------------------------------
  // operation codes and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MUL = 8'h1C;
  localparam logic [7:0] OP_MUL_FLAGS = 8'h8F;
  localparam logic [7:0] OP_LESS_FLAGS = 8'h91;
  localparam int MUL_LATENCY = 3;
  localparam int CMP_LATENCY = 1;
  localparam int LANES = 2;
  localparam int CMP_LANE = 1;

  // ----------------------------------------------------------------
  // exception vector bit positions (same layout as status word)
  // ----------------------------------------------------------------
  localparam int FLAG_W = 7;
  localparam int INEXACT_BIT = 1;
  localparam int UNDERFLOW_BIT = 2;
  localparam int OVERFLOW_BIT = 3;
  localparam int INVALID_BIT = 4;
  localparam int IFZ_BIT = 5;
  localparam int OFZ_BIT = 6;
  localparam logic [FLAG_W-1:0] FLAG_MASK = 7'h7E;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;

  // ----------------------------------------------------------------
  // float patterns and exponent limits
  // ----------------------------------------------------------------
  localparam logic [31:0] QNAN_PAT = 32'hFFFFFFFF;
  localparam logic [30:0] INF_MAG = 31'h7F800000;
  localparam logic [30:0] MAX_MAG = 31'h7F7FFFFF;
  localparam logic signed [10:0] EXP_BIAS = 11'sd127;
  localparam logic signed [10:0] EXP_MAX = 11'sd255;
  localparam logic signed [10:0] OFZ_LIMIT = -11'sd24;

  // ----------------------------------------------------------------
  // status word register
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RM_NEAREST = 2'h0, RM_ZERO = 2'h1, RM_POS = 2'h2,
                            RM_NEG = 2'h3} round_mode_t;
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] STATUS_WORD_OFS = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] PIPE_STATE_OFS = 8'h04;
  localparam int RM_POS_LSB = 8;
  localparam logic [1:0] RM_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fp_mul_cmp_pkg

// ---- fp_multiply_compare_flags.sv ----
`timescale 1ns/1ps
module fp_multiply_compare_flags
  import fp_mul_cmp_pkg::*;
#(
  parameter int DEST_W = 7
)(
  input wire logic sys_clk,
  input wire logic sys_rst,
  // issue side: lane 0 is slot 2, lane 1 is slot 3
  input wire logic [LANES-1:0] issueValid,
  input wire logic [LANES-1:0][7:0] issueOpCode,
  input wire logic [LANES-1:0] issueGuard,
  input wire logic [LANES-1:0][31:0] firstSource,
  input wire logic [LANES-1:0][31:0] secondSource,
  input wire logic [LANES-1:0][DEST_W-1:0] issueDest,
  // multiply unit write-back, one per lane
  output logic [LANES-1:0] wbValid,
  output logic [LANES-1:0][31:0] wbData,
  output logic [LANES-1:0][DEST_W-1:0] wbDest,
  // compare unit write-back
  output logic cmpValid,
  output logic [31:0] cmpData,
  output logic [DEST_W-1:0] cmpDest,
  // status word flags as seen by the core
  output logic [FLAG_W-1:0] procStatusFlags,
  // axi4-lite register slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic is_denorm(input logic [31:0] x);
    is_denorm = (x[30:23] == 8'h00) && (x[22:0] != 23'h0);
  endfunction : is_denorm

  function automatic logic is_nan(input logic [31:0] x);
    is_nan = (x[30:23] == 8'hFF) && (x[22:0] != 23'h0);
  endfunction : is_nan

  // returns {flags, result}; denormal inputs count as zero
  function automatic logic [FLAG_W+31:0] fp_mul(input logic [31:0] a,
                                                input logic [31:0] b,
                                                input logic [1:0] rm);
    logic sr;
    logic zA;
    logic zB;
    logic infA;
    logic infB;
    logic inc;
    logic grd;
    logic stk;
    logic [47:0] p;
    logic [24:0] m;
    logic signed [10:0] e;
    logic [FLAG_W-1:0] fl;
    logic [31:0] res;
    sr = a[31] ^ b[31];
    zA = (a[30:23] == 8'h00);
    zB = (b[30:23] == 8'h00);
    infA = (a[30:0] == INF_MAG);
    infB = (b[30:0] == INF_MAG);
    inc = 1'b0;
    grd = 1'b0;
    stk = 1'b0;
    p = '0;
    m = '0;
    e = '0;
    fl = '0;
    res = '0;
    if (is_nan(a) || is_nan(b))
    begin
      res = QNAN_PAT;
      fl[INVALID_BIT] = (is_nan(a) && !a[22]) || (is_nan(b) && !b[22]);
    end
    else if ((infA && zB) || (infB && zA))
    begin
      res = QNAN_PAT;
      fl[INVALID_BIT] = 1'b1;
    end
    else if (infA || infB)
      res = {sr, INF_MAG};
    else if (zA || zB)
      res = {sr, 31'h0};
    else
    begin
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = $signed({3'b000, a[30:23]}) + $signed({3'b000, b[30:23]}) - EXP_BIAS;
      if (p[47])
        e = e + 11'sd1;
      else
        p = {p[46:0], 1'b0};
      grd = p[23];
      stk = |p[22:0];
      // rounding follows the status word mode
      case (rm)
        RM_NEAREST: inc = grd && (stk || p[24]);
        RM_ZERO: inc = 1'b0;
        RM_POS: inc = !sr && (grd || stk);
        RM_NEG: inc = sr && (grd || stk);
        default: inc = 1'b0;
      endcase
      m = {1'b0, p[47:24]} + {24'h0, inc};
      if (m[24])
      begin
        e = e + 11'sd1;
        m = {1'b0, m[24:1]};
      end
      if (e >= EXP_MAX)
      begin
        fl[OVERFLOW_BIT] = 1'b1;
        fl[INEXACT_BIT] = 1'b1;
        if (rm == RM_ZERO || (rm == RM_POS && sr) || (rm == RM_NEG && !sr))
          res = {sr, MAX_MAG};
        else
          res = {sr, INF_MAG};
      end
      else if (e <= 11'sd0)
      begin
        // flushed tiny results are never exact
        res = {sr, 31'h0};
        fl[UNDERFLOW_BIT] = 1'b1;
        fl[INEXACT_BIT] = 1'b1;
        fl[OFZ_BIT] = (e > OFZ_LIMIT);
      end
      else
      begin
        res = {sr, e[7:0], m[22:0]};
        fl[INEXACT_BIT] = grd || stk;
      end
    end
    fl[IFZ_BIT] = is_denorm(a) || is_denorm(b);
    fp_mul = {fl & FLAG_MASK, res};
  endfunction : fp_mul

  // flags of an ordered greater-than compare x > y
  function automatic logic [FLAG_W-1:0] gtr_flags(input logic [31:0] x,
                                                  input logic [31:0] y);
    logic [FLAG_W-1:0] fl;
    fl = '0;
    fl[INVALID_BIT] = is_nan(x) || is_nan(y);
    fl[IFZ_BIT] = is_denorm(x) || is_denorm(y);
    gtr_flags = fl;
  endfunction : gtr_flags

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [1:0] roundMode_r;
  logic [LANES-1:0] mulGo;
  logic [LANES-1:0] isFlagsOp;
  logic cmpGo;
  logic [FLAG_W+31:0] mulOut [LANES];
  logic [LANES-1:0] s1Valid_r;
  logic [LANES-1:0] s1FlagsOnly_r;
  logic [31:0] s1Res_r [LANES];
  logic [FLAG_W-1:0] s1Flags_r [LANES];
  logic [DEST_W-1:0] s1Dest_r [LANES];
  logic [LANES-1:0] s2Valid_r;
  logic [LANES-1:0] s2FlagsOnly_r;
  logic [31:0] s2Res_r [LANES];
  logic [FLAG_W-1:0] s2Flags_r [LANES];
  logic [DEST_W-1:0] s2Dest_r [LANES];
  logic awHeld_r;
  logic wHeld_r;
  logic [AXI_ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic statusWrite;

  // ----------------------------------------------------------------
  // issue decode
  // ----------------------------------------------------------------
  // a false guard keeps the op out of the pipe, so nothing is written
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      isFlagsOp[i] = (issueOpCode[i] == OP_MUL_FLAGS);
      mulGo[i] = issueValid[i] && issueGuard[i] &&
                 (issueOpCode[i] == OP_MUL || isFlagsOp[i]);
      mulOut[i] = fp_mul(firstSource[i], secondSource[i], roundMode_r);
    end
  end

  // compare is only decoded in the slot 3 lane
  assign cmpGo = issueValid[CMP_LANE] && issueGuard[CMP_LANE] &&
                 (issueOpCode[CMP_LANE] == OP_LESS_FLAGS);

  // ----------------------------------------------------------------
  // multiply pipeline, three stages
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s1Valid_r <= '0;
      s2Valid_r <= '0;
      wbValid <= '0;
    end
    else
    begin
      s1Valid_r <= mulGo;
      s2Valid_r <= s1Valid_r;
      wbValid <= s2Valid_r;
    end
  end

  // payload carries no reset; valid bits qualify it
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      s1Res_r[i] <= mulOut[i][31:0];
      s1Flags_r[i] <= mulOut[i][FLAG_W+31:32];
      s1FlagsOnly_r[i] <= isFlagsOp[i];
      s1Dest_r[i] <= issueDest[i];
      s2Res_r[i] <= s1Res_r[i];
      s2Flags_r[i] <= s1Flags_r[i];
      s2FlagsOnly_r[i] <= s1FlagsOnly_r[i];
      s2Dest_r[i] <= s1Dest_r[i];
    end
  end

  // write-back registers; flags ops return the vector, upper bits zero
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wbData <= '0;
      wbDest <= '0;
    end
    else
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (s2Valid_r[i])
        begin
          wbDest[i] <= s2Dest_r[i];
          if (s2FlagsOnly_r[i])
            wbData[i] <= {25'h0, s2Flags_r[i]};
          else
            wbData[i] <= s2Res_r[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // compare-flags unit, one stage
  // ----------------------------------------------------------------
  // less-than runs as greater-than on swapped operands
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cmpValid <= 1'b0;
      cmpData <= '0;
      cmpDest <= '0;
    end
    else
    begin
      cmpValid <= cmpGo;
      if (cmpGo)
      begin
        cmpData <= {25'h0, gtr_flags(secondSource[CMP_LANE],
                                     firstSource[CMP_LANE])};
        cmpDest <= issueDest[CMP_LANE];
      end
    end
  end

  // ----------------------------------------------------------------
  // status word flags
  // ----------------------------------------------------------------
  // flags land on the edge that loads wbValid; a hardware set beats a
  // same-cycle software clear, and flags-only ops never touch them
  always_comb
  begin
    flags_nxt = flags_r;
    if (statusWrite && wStrb_r[0])
      flags_nxt = wData_r[FLAG_W-1:0] & FLAG_MASK;
    for (int i = 0; i < LANES; i++)
    begin
      if (s2Valid_r[i] && !s2FlagsOnly_r[i])
        flags_nxt = flags_nxt | s2Flags_r[i];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      flags_r <= FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  assign procStatusFlags = flags_r;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      roundMode_r <= RM_RST;
    else if (statusWrite && wStrb_r[1])
      roundMode_r <= wData_r[RM_POS_LSB+1:RM_POS_LSB];
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are caught in either order; one write at a time
  assign statusWrite = awHeld_r && wHeld_r && !bvalid &&
                       (awAddr_r == STATUS_WORD_OFS);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_r <= 1'b1;
        awready <= 1'b0;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_r <= 1'b1;
        wready <= 1'b0;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (awHeld_r && wHeld_r && !bvalid)
      begin
        bvalid <= 1'b1;
        bresp <= (awAddr_r == STATUS_WORD_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (araddr)
        STATUS_WORD_OFS: rdata <= {22'h0, roundMode_r, 1'b0, flags_r};
        PIPE_STATE_OFS: rdata <= {25'h0, cmpValid, wbValid, s2Valid_r, s1Valid_r};
        default:
        begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_mul_latency:
    assert property (mulGo[0] && !isFlagsOp[0] |-> ##3 wbValid[0])
      else $error("multiply result not written three cycles after issue");

  chk_mulflags_latency:
    assert property (wbValid[1] |-> $past(mulGo[1], 3))
      else $error("lane write-back without an issue three cycles before");

  chk_cmp_latency:
    assert property (cmpGo |=> cmpValid && cmpDest == $past(issueDest[CMP_LANE]))
      else $error("compare flags not returned after one cycle");

  chk_guard_blocks:
    assert property (issueValid[0] && !issueGuard[0] |-> ##3 !wbValid[0])
      else $error("guarded-off multiply wrote a result");

  chk_flags_sticky:
    assert property (|($past(flags_r) & ~flags_r) |-> $past(statusWrite))
      else $error("status flag dropped without a status write");

  chk_flag_merge:
    assert property (wbValid[0] && !$past(s2FlagsOnly_r[0]) && !$past(statusWrite)
                     |-> (flags_r & $past(s2Flags_r[0])) == $past(s2Flags_r[0])
                         && (flags_r & $past(flags_r)) == $past(flags_r))
      else $error("multiply flags not merged into status word");

  chk_vector_upper:
    assert property (cmpValid |-> cmpData[31:FLAG_W] == '0 && !cmpData[0])
      else $error("undefined exception vector bits are set");

  chk_cmp_nan:
    assert property (cmpGo && is_nan(firstSource[CMP_LANE])
                     |=> cmpData[INVALID_BIT])
      else $error("NaN compare did not flag invalid");

  chk_inf_zero:
    assert property (mulGo[0] && !isFlagsOp[0] &&
                     firstSource[0][30:0] == INF_MAG && secondSource[0] == 32'h0
                     |-> ##3 wbData[0] == QNAN_PAT)
      else $error("infinity times zero did not give the NaN pattern");

  cov_dual_multiply: cover property (wbValid[0] && wbValid[1]);
  cov_cmp_and_mul: cover property (cmpValid && wbValid[1]);
  cov_set_on_clear: cover property (statusWrite && s2Valid_r[0] && !s2FlagsOnly_r[0]);

endmodule : fp_multiply_compare_flags

// ---- regfile_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register file behind the multiply lanes and the compare port
// ----------------------------------------------------------------
module regfile_model
  import fp_mul_cmp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [LANES-1:0] wbValid,
  input wire logic [LANES-1:0][31:0] wbData,
  input wire logic [LANES-1:0][6:0] wbDest,
  input wire logic cmpValid,
  input wire logic [31:0] cmpData,
  input wire logic [6:0] cmpDest,
  input wire logic [6:0] rdIdx,
  output logic [31:0] rdData
);
  logic [31:0] regs [128];

  // an entry changes only on a strobe, so a refused op leaves it alone
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wbValid[i])
      begin
        regs[wbDest[i]] <= wbData[i];
      end
    end
    if (cmpValid)
    begin
      regs[cmpDest] <= cmpData;
    end
  end

  assign rdData = regs[rdIdx]; // unwritten entries stay unknown
endmodule : regfile_model

// ---- fp_multiply_compare_flags_tb_top.sv ----
`timescale 1ns/1ps
module fp_multiply_compare_flags_tb_top
  import fp_mul_cmp_pkg::*;
;
  localparam logic [31:0] P3 = 32'h40400000;
  localparam logic [31:0] M3 = 32'hC0400000;
  localparam logic [31:0] ONE = 32'h3F800000;
  localparam logic [31:0] MINN = 32'h00800000;
  localparam logic [31:0] DEN = 32'h00400000;
  localparam logic [31:0] INF = 32'h7F800000;
  localparam logic [31:0] MAXF = 32'h7F7FFFFF;
  localparam logic [31:0] QN = 32'hFFFFFFFF;
  logic sys_clk, sys_rst, cmpValid, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [LANES-1:0] issueValid, issueGuard, wbValid;
  logic [LANES-1:0][7:0] issueOpCode;
  logic [LANES-1:0][31:0] firstSource, secondSource, wbData;
  logic [LANES-1:0][6:0] issueDest, wbDest;
  logic [31:0] cmpData, wdata, rdata, rdData;
  logic [6:0] cmpDest, rdIdx;
  logic [FLAG_W-1:0] procStatusFlags;
  logic [7:0] awaddr, araddr;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int num_checks = 0;

  fp_multiply_compare_flags DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .issueValid(issueValid), .issueOpCode(issueOpCode), .issueGuard(issueGuard),
    .firstSource(firstSource), .secondSource(secondSource), .issueDest(issueDest),
    .wbValid(wbValid), .wbData(wbData), .wbDest(wbDest), .cmpValid(cmpValid),
    .cmpData(cmpData), .cmpDest(cmpDest), .procStatusFlags(procStatusFlags),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  regfile_model PARTNER (.sys_clk(sys_clk), .wbValid(wbValid), .wbData(wbData),
    .wbDest(wbDest), .cmpValid(cmpValid), .cmpData(cmpData), .cmpDest(cmpDest),
    .rdIdx(rdIdx), .rdData(rdData));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // called just after an edge; the op is taken at the next edge
  task automatic launch(input int ln, input logic [7:0] op, input logic g,
                        input logic [31:0] a, input logic [31:0] b);
    issueValid[ln] <= 1'b1;
    issueOpCode[ln] <= op;
    issueGuard[ln] <= g;
    firstSource[ln] <= a;
    secondSource[ln] <= b;
    issueDest[ln] <= 7'(ln + 5);
  endtask : launch

  // nothing may show one cycle early; leaves us just after the answer edge
  task automatic await(input int lat);
    @(posedge sys_clk);
    issueValid <= '0;
    repeat (lat - 1)
    begin
      #1;
      chk({wbValid, cmpValid}, 32'h0);
      @(posedge sys_clk);
    end
    #1;
  endtask : await

  task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data,
                          input logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr <= addr;
    wvalid <= 1'b1;
    wdata <= data;
    bready <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge sys_clk);
      if (!awDone && awready === 1'b1)
      begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1)
      begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, resp);
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] addr, input logic [31:0] exp,
                         input logic [1:0] resp);
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr <= addr;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk(rresp, resp);
  endtask : axiRead

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // product and status first, then the flags-only twin on the same operands
  task automatic mulCase(input int ln, input logic [31:0] a, input logic [31:0] b,
                         input logic [31:0] prod, input logic [6:0] fl);
    axiWrite(STATUS_WORD_OFS, 32'h0, RESP_OKAY);
    @(posedge sys_clk);
    launch(ln, OP_MUL, 1'b1, a, b);
    await(MUL_LATENCY);
    chk(wbValid[ln], 1'b1);
    chk(wbDest[ln], 7'(ln + 5));
    chk(wbData[ln], prod);
    chk(procStatusFlags, fl);
    @(posedge sys_clk);
    launch(ln, OP_MUL_FLAGS, 1'b1, a, b);
    await(MUL_LATENCY);
    chk(wbData[ln], {25'h0, fl});
    chk(procStatusFlags, fl);
    $display("multiply case done");
  endtask : mulCase

  // both lanes at once, then more updates on top of what is held
  task automatic stickyTest;
    axiWrite(STATUS_WORD_OFS, 32'h0, RESP_OKAY);
    @(posedge sys_clk);
    launch(0, OP_MUL, 1'b1, INF, 32'h0);
    launch(1, OP_MUL, 1'b1, MAXF, MAXF);
    await(MUL_LATENCY);
    chk(procStatusFlags, 7'h1A);
    @(posedge sys_clk);
    launch(0, OP_MUL, 1'b1, M3, ONE);
    await(MUL_LATENCY);
    chk(procStatusFlags, 7'h1A);
    @(posedge sys_clk);
    launch(1, OP_MUL, 1'b1, 32'h3F000000, MINN);
    await(MUL_LATENCY);
    chk(procStatusFlags, 7'h5E);
    axiRead(STATUS_WORD_OFS, 32'h5E, RESP_OKAY);
    axiWrite(STATUS_WORD_OFS, 32'h0, RESP_OKAY);
    #1;
    chk(procStatusFlags, 7'h0);
    $display("sticky test done");
  endtask : stickyTest

  // a false guard must leave register file and status alone
  task automatic guardTest;
    rdIdx = 7'h05;
    @(posedge sys_clk);
    launch(0, OP_MUL, 1'b1, P3, M3);
    await(MUL_LATENCY);
    @(posedge sys_clk);
    launch(0, OP_MUL, 1'b0, INF, 32'h0);
    launch(1, OP_MUL_FLAGS, 1'b0, INF, 32'h0);
    await(MUL_LATENCY);
    chk(wbValid, 32'h0);
    chk(procStatusFlags, 7'h0);
    chk(rdData, 32'hC1100000);
    @(posedge sys_clk);
    launch(1, OP_LESS_FLAGS, 1'b0, P3, QN);
    launch(0, OP_LESS_FLAGS, 1'b1, P3, QN);
    await(CMP_LATENCY);
    chk(cmpValid, 1'b0);
    $display("guard test done");
  endtask : guardTest

  task automatic lessCase(input logic [31:0] a, input logic [31:0] b,
                          input logic [6:0] fl);
    @(posedge sys_clk);
    launch(1, OP_LESS_FLAGS, 1'b1, a, b);
    await(CMP_LATENCY);
    chk(cmpValid, 1'b1);
    chk(cmpData, {25'h0, fl});
    chk(procStatusFlags, 7'h0);
    $display("compare case done");
  endtask : lessCase

  // toward-zero mode clamps an overflow to the largest finite value
  task automatic roundAndBusTest;
    axiWrite(STATUS_WORD_OFS, 32'h100, RESP_OKAY);
    @(posedge sys_clk);
    launch(1, OP_MUL, 1'b1, MAXF, MAXF);
    await(MUL_LATENCY);
    chk(wbData[1], MAXF);
    axiRead(STATUS_WORD_OFS, 32'h10A, RESP_OKAY);
    axiWrite(PIPE_STATE_OFS, 32'h7F, RESP_SLVERR);
    axiRead(8'h08, 32'h0, RESP_SLVERR);
    axiWrite(STATUS_WORD_OFS, 32'h0, RESP_OKAY);
    $display("rounding and bus test done");
  endtask : roundAndBusTest

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // whole run is a few hundred cycles; this ceiling only catches a hang
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    sys_rst = 1'b1;
    {issueValid, issueGuard, issueOpCode, firstSource, secondSource, issueDest} = '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    rdIdx = 7'h0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(procStatusFlags, 7'h0);
    chk({wbValid, cmpValid}, 32'h0);
    mulCase(0, M3, ONE, M3, 7'h00);
    mulCase(1, P3, M3, 32'hC1100000, 7'h00);
    mulCase(0, P3, MINN, 32'h01400000, 7'h00);
    mulCase(1, 32'h3F000000, MINN, 32'h0, 7'h46);
    mulCase(0, INF, 32'h0, QN, 7'h10);
    mulCase(1, P3, DEN, 32'h0, 7'h20);
    mulCase(0, INF, 32'hFF800000, 32'hFF800000, 7'h00);
    mulCase(1, MAXF, MAXF, INF, 7'h0A);
    mulCase(0, MINN, MINN, 32'h0, 7'h06);
    stickyTest();
    guardTest();
    lessCase(P3, 32'h0, 7'h00);
    lessCase(P3, QN, 7'h10);
    lessCase(ONE, DEN, 7'h20);
    lessCase(INF, 32'hFF800000, 7'h00);
    lessCase(DEN, QN, 7'h30);
    roundAndBusTest();
    final_report();
  end
endmodule : fp_multiply_compare_flags_tb_top
